// >>> flash_master_pkg.sv
// What this block does
// - Data out and select change on falling edges, except at byte start, where select falls and the first bit is set in idle.
// - Flash read data captured on falling edge.
// - Serial clock programmable, 1.45 to 16.7 MHz.
// - Handles flash sizes from 1 to 128 Mb.
`default_nettype none
package flash_master_pkg;
  // The serial engine runs on the oscillator-derived core clock.
  localparam int LINK_PERIOD_PS = 15000;
  localparam int SCLK_FMIN_KHZ = 1400;
  localparam int SCLK_FMAX_KHZ = 36000;
  localparam int HALF_MAX_PS = 500000000 / SCLK_FMIN_KHZ;
  localparam int HALF_MIN_PS = (500000000 + SCLK_FMAX_KHZ - 1) / SCLK_FMAX_KHZ;
  localparam int HALF_MAX_RAW = HALF_MAX_PS / LINK_PERIOD_PS;
  localparam int HALF_MIN_RAW =
    (HALF_MIN_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  // The input synchroniser costs two core cycles, so a half period
  // shorter than that would capture the previous bit.
  localparam int SYNC_DEPTH = 2;
  // Reference cycles for which the serial side is held in reset, so
  // that a two-cycle system reset still reaches the slower clock.
  localparam logic [2:0] RST_STRETCH = 3'h7;
  localparam int HALF_MIN_CYC =
    (HALF_MIN_RAW > SYNC_DEPTH) ? HALF_MIN_RAW : SYNC_DEPTH;
  localparam int HALF_MAX_CYC = (HALF_MAX_RAW > 0) ? HALF_MAX_RAW : 1;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] HALF_MIN = DIV_W'(HALF_MIN_CYC);
  localparam logic [DIV_W-1:0] HALF_MAX = DIV_W'(HALF_MAX_CYC);
  // Largest part: 128 Mb, i.e. 16 MB, reached with 3 address bytes.
  localparam int FLASH_MAX_MBIT = 128;
  localparam int FLASH_ADDR_BITS = $clog2(FLASH_MAX_MBIT * 1024 * 1024 / 8);
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST = HALF_MAX;
  typedef enum logic [2:0] {
    L_IDLE = 3'b001,
    L_LOW = 3'b010,
    L_HIGH = 3'b100
  } link_state_t;
  function automatic logic [DIV_W-1:0] clamp_half(input logic [DIV_W-1:0] d);
    logic [DIV_W-1:0] r;
    r = d;
    if (d < HALF_MIN) begin
      r = HALF_MIN;
    end else if (d > HALF_MAX) begin
      r = HALF_MAX;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  // Flash pins
  input wire logic flash_sclk,
  input wire logic flash_select_n,
  input wire logic flash_dout,
  output logic flash_din,
  // Observation
  output logic [7:0] last_rx,
  output logic [3:0] n_bytes
);
  logic [7:0] sh, tx;
  logic [2:0] cnt, ob;
  initial begin
    {flash_din, sh, tx, cnt, ob, n_bytes, last_rx} = '0;
  end
  // The first byte of a selection answers ff, each later one the inverse of the last byte received.
  always @(posedge flash_sclk) begin
    sh = {sh[6:0], flash_dout};
    cnt = cnt + 3'h1;
    if (cnt == 3'h0) begin
      last_rx = sh;
      n_bytes = n_bytes + 4'h1;
    end
  end
  always @(negedge flash_sclk) begin
    ob = ob + 3'h1;
    if (ob == 3'h0) tx = ~last_rx;
    flash_din = tx[3'h7 - ob];
  end
  always @(flash_select_n) begin
    {cnt, ob, tx} = {6'h00, 8'hff};
    if (!flash_select_n) n_bytes = 4'h0;
    // A released line keeps no value, so show the inverse.
    flash_din = flash_select_n ? ~flash_din : tx[7];
  end
endmodule
`default_nettype wire

// >>> serial_flash_master.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_master (
  // System side
  input wire logic ref_clk,
  input wire logic rst_n,
  // Byte stream in
  input wire logic tx_valid,
  input wire logic [flash_master_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_last,
  input wire logic [flash_master_pkg::DIV_W-1:0] sclk_half_cycles,
  output logic tx_ready,
  // Byte stream out
  output logic rx_valid,
  output logic [flash_master_pkg::BYTE_W-1:0] rx_data,
  output logic busy,
  // Serial clock source
  input wire logic core_osc_clk,
  // Flash pins
  output logic flash_sclk,
  output logic flash_select_n,
  output logic flash_dout,
  input wire logic flash_din
);
  import flash_master_pkg::*;

  // Held across the crossing; stable from a request toggle to its ack.
  logic [BYTE_W-1:0] hold_byte;
  logic hold_last;
  logic [DIV_W-1:0] hold_div;
  logic req_tgl;
  logic ack_s1, ack_s2, ack_seen;

  logic lrst_s1, link_rst_n;
  logic [2:0] rst_stretch;
  logic link_go;
  logic req_s1, req_s2, req_seen;
  logic din_s1, din_s2;
  logic ack_tgl;
  logic [BYTE_W-1:0] rx_hold;
  link_state_t state;
  logic [DIV_W-1:0] cur_div, cnt;
  logic cur_last;
  logic [BYTE_W-1:0] shift_out, shift_in;
  logic [2:0] bit_cnt;

  always_ff @(posedge ref_clk) begin
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
  end

  // One byte is in flight at a time; the source holds tx_valid and
  // its data until the tx_ready pulse.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_byte <= BYTE_RST;
      hold_last <= 1'b0;
      hold_div <= DIV_RST;
      req_tgl <= 1'b0;
      ack_seen <= 1'b0;
      busy <= 1'b0;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= BYTE_RST;
    end else begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      if (!busy && !tx_ready && tx_valid) begin
        hold_byte <= tx_data;
        hold_last <= tx_last;
        hold_div <= sclk_half_cycles;
        req_tgl <= ~req_tgl;
        busy <= 1'b1;
        tx_ready <= 1'b1;
      end else if (ack_s2 != ack_seen) begin
        ack_seen <= ack_s2;
        rx_data <= rx_hold;
        rx_valid <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

  // A reset of a couple of reference cycles may fall between two serial
  // clock edges, so it is stretched before it crosses.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rst_stretch <= RST_STRETCH;
      link_go <= 1'b0;
    end else begin
      if (rst_stretch != 3'h0) begin
        rst_stretch <= rst_stretch - 3'h1;
      end
      link_go <= (rst_stretch == 3'h0);
    end
  end

  always_ff @(posedge core_osc_clk) begin
    lrst_s1 <= link_go;
    link_rst_n <= lrst_s1;
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    din_s1 <= flash_din;
    din_s2 <= din_s1;
  end

  // Serial engine, mode 0: clock idles low, the flash takes data on the
  // rising edge, and our launches and captures sit on the fall, except the first bit of each byte, set in L_IDLE.
  always_ff @(posedge core_osc_clk) begin
    if (!link_rst_n) begin
      state <= L_IDLE;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rx_hold <= BYTE_RST;
      cur_div <= DIV_RST;
      cnt <= '0;
      cur_last <= 1'b0;
      shift_out <= BYTE_RST;
      shift_in <= BYTE_RST;
      bit_cnt <= '0;
      flash_sclk <= 1'b0;
      flash_select_n <= 1'b1;
      flash_dout <= 1'b0;
    end else begin
      unique case (state)
        L_IDLE: begin
          if (req_s2 != req_seen) begin
            req_seen <= req_s2;
            cur_div <= clamp_half(hold_div);
            cur_last <= hold_last;
            flash_select_n <= 1'b0;
            flash_dout <= hold_byte[BYTE_W-1];
            shift_out <= {hold_byte[BYTE_W-2:0], 1'b0};
            bit_cnt <= '0;
            cnt <= '0;
            state <= L_LOW;
          end
        end
        L_LOW: begin
          if (cnt == cur_div - 1'b1) begin
            cnt <= '0;
            flash_sclk <= 1'b1;
            state <= L_HIGH;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        L_HIGH: begin
          if (cnt == cur_div - 1'b1) begin
            cnt <= '0;
            flash_sclk <= 1'b0;
            shift_in <= {shift_in[BYTE_W-2:0], din_s2};
            flash_dout <= shift_out[BYTE_W-1];
            shift_out <= {shift_out[BYTE_W-2:0], 1'b0};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == LAST_BIT) begin
              rx_hold <= {shift_in[BYTE_W-2:0], din_s2};
              ack_tgl <= ~ack_tgl;
              if (cur_last) begin
                flash_select_n <= 1'b1;
              end
              state <= L_IDLE;
            end else begin
              state <= L_LOW;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Checks on the serial side.
  logic [DIV_W:0] high_run;
  always_ff @(posedge core_osc_clk) begin
    if (!link_rst_n || !flash_sclk) begin
      high_run <= '0;
    end else begin
      high_run <= high_run + 1'b1;
    end
  end

  property p_dout_on_fall;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    $changed(flash_dout) |-> !flash_sclk;
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall)
    else $error("Data out changed while serial clock high.");

  property p_select_on_fall;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    $rose(flash_select_n) |-> $fell(flash_sclk);
  endproperty
  a_select_on_fall: assert property (p_select_on_fall)
    else $error("Select released away from a falling edge.");

  property p_capture_on_fall;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    $changed(shift_in) |-> $fell(flash_sclk);
  endproperty
  a_capture_on_fall: assert property (p_capture_on_fall)
    else $error("Read data captured away from a falling edge.");

  property p_high_width;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    $fell(flash_sclk) |->
      $past(high_run) + 1'b1 >= {1'b0, HALF_MIN} &&
      $past(high_run) + 1'b1 <= {1'b0, HALF_MAX};
  endproperty
  a_high_width: assert property (p_high_width)
    else $error("Serial clock high time out of range.");

  // The counter saturates, since the low time between bytes is set by
  // the source and has no upper limit; only the lower bound is checked.
  logic [DIV_W:0] low_run;
  always_ff @(posedge core_osc_clk) begin
    if (!link_rst_n || flash_sclk) begin
      low_run <= '0;
    end else if (low_run != '1) begin
      low_run <= low_run + 1'b1;
    end
  end

  property p_low_width;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    $rose(flash_sclk) |-> $past(low_run) >= {1'b0, HALF_MIN - 1'b1};
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("Serial clock low time too short.");

  property p_idle_clock;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    flash_select_n |-> !flash_sclk;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("Serial clock active while deselected.");

  property p_select_held;
    @(posedge core_osc_clk) disable iff (!link_rst_n)
    $fell(flash_select_n) |-> !flash_select_n [*2];
  endproperty
  a_select_held: assert property (p_select_held)
    else $error("Select dropped out inside a byte.");
endmodule
`default_nettype wire

// >>> test_serial_flash_master.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_master;
  import flash_master_pkg::*;
  logic ref_clk = 0, rst_n = 0, core_osc_clk = 0;
  logic tx_valid = 0, tx_last = 0, tx_ready, rx_valid, busy;
  logic [7:0] tx_data = 8'h00, sclk_half_cycles = 8'h04, rx_data, last_rx;
  logic flash_sclk, flash_select_n, flash_dout, flash_din;
  logic [3:0] n_bytes;
  logic [7:0] hi = 8'h00, hi_len = 8'h00;
  logic p_sclk = 0, p_dout = 0, p_sel = 1;
  int n_fail = 0, total_checks = 0, n_bad = 0;
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #3.3;
    forever #7.5 core_osc_clk = ~core_osc_clk;
  end
  serial_flash_master serial_flash_master_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .sclk_half_cycles(sclk_half_cycles),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .busy(busy), .core_osc_clk(core_osc_clk), .flash_sclk(flash_sclk),
    .flash_select_n(flash_select_n), .flash_dout(flash_dout),
    .flash_din(flash_din));
  flash_model flash_model_i (.flash_sclk(flash_sclk),
    .flash_select_n(flash_select_n), .flash_dout(flash_dout),
    .flash_din(flash_din), .last_rx(last_rx), .n_bytes(n_bytes));
  // Pins are watched in the serial clock's own domain.
  always @(posedge core_osc_clk) begin
    if (flash_sclk) hi <= hi + 8'h01;
    else if (hi != 8'h00) begin
      hi_len <= hi;
      hi <= 8'h00;
    end
    if (p_sclk && flash_sclk &&
        {flash_dout, flash_select_n} != {p_dout, p_sel})
      n_bad++;
    if (flash_select_n && flash_sclk) n_bad++;
    {p_sclk, p_dout, p_sel} <= {flash_sclk, flash_dout, flash_select_n};
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask
  task automatic send(input logic [7:0] d, input logic last,
                      input logic [7:0] h, input logic [7:0] exp_rx);
    int i;
    @(negedge ref_clk);
    {tx_valid, tx_data, tx_last, sclk_half_cycles} = {1'b1, d, last, h};
    i = 0;
    while (tx_ready !== 1'b1 && i < 50) begin
      @(negedge ref_clk);
      i++;
    end
    check("tx_ready", {7'h00, tx_ready}, 8'h01);
    check("busy", {7'h00, busy}, 8'h01);
    tx_valid = 0;
    while (rx_valid !== 1'b1 && i < 3000) begin
      @(negedge ref_clk);
      i++;
    end
    check("rx_valid", {7'h00, rx_valid}, 8'h01);
    check("busy", {7'h00, busy}, 8'h00);
    check("rx_data", rx_data, exp_rx);
    check("flash_rx", last_rx, d);
    check("select_n", {7'h00, flash_select_n}, {7'h00, last});
  endtask
  // Out-of-range settings must clamp to the legal clock range.
  task automatic t_rate();
    send(8'ha5, 1'b1, 8'h01, 8'hff);
    check("half", hi_len, HALF_MIN);
    send(8'h3c, 1'b1, 8'h05, 8'hff);
    check("half", hi_len, 8'h05);
    send(8'h96, 1'b1, 8'hc8, 8'hff);
    check("half", hi_len, HALF_MAX);
  endtask
  // Command plus three address bytes reaches the largest part.
  task automatic t_burst();
    send(8'h03, 1'b0, 8'h02, 8'hff);
    send(8'hff, 1'b0, 8'h02, 8'hfc);
    send(8'h00, 1'b0, 8'h02, 8'h00);
    send(8'h81, 1'b1, 8'h02, 8'hff);
    check("n_bytes", {4'h0, n_bytes},
          8'(1 + FLASH_ADDR_BITS / BYTE_W));
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    t_rate();
    t_burst();
    check("pin_faults", n_bad[7:0], 8'h00);
    end_of_test();
  end
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
